// ==== fei_framer_irq.sv ====
// Framer event flags, interrupt output, SLC-96 overhead and E1 reporting
module fei_framer_irq
   import fei_pkg::*;
#(
   parameter int RED_COUNT = RED_CYCLES
)
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Receive framer side
   input  wire fei_fmt_t    fmt,
   input  wire fei_evt_t    evt,
   input  wire fei_slc_t    slc,
   input  wire fei_e1_t     e1,
   // Outputs
   output logic             intN,
   output logic             reframeReq,
   output logic             ts16Out,
   output logic             bypass
);

   // Bus registers
   logic [7:0]  mode0_ff, mode1_ff, en0_ff, en1_ff, slcEn_ff, e1Ctrl_ff, saSel_ff;
   logic [7:0]  flg0_ff, flg1_ff, slcFlg_ff, e1Flg_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff, pslverr_ff;
   // Block state
   logic        oofState_ff, refrLast_ff, intN_ff, reframe_ff, ts16_ff;
   logic [10:0] conc_ff;
   logic [2:0]  maint_ff;
   logic [1:0]  alarm_ff;
   logic [3:0]  sw_ff;
   logic [1:0]  si_ff;
   logic [4:0]  sa_ff;
   logic [2:0]  xbits_ff;
   logic [3:0]  codeShift_ff, code_ff;
   logic [2:0]  codeCnt_ff;
   logic [1:0]  rawRem, remVal_ff, remLast_ff;
   logic [2:0]  remCnt_ff [2];
   logic [8:0]  aisBits_ff, aisZeros_ff;
   logic        ais_ff, red_ff;
   logic [19:0] redCnt_ff;

   function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
      return a[11:2] == idx && a[1:0] == 2'h0;
   endfunction

   // Bus decode
   wire         access   = psel & penable & pready_ff;
   wire         wrStb    = access & pwrite;
   wire [7:0]   wd       = pwdata[7:0];
   wire         wMode0   = wrStb & hit(paddr, IDX_MODE0);
   wire         wFlg0    = wrStb & hit(paddr, IDX_FLG0);
   wire         wFlg1    = wrStb & hit(paddr, IDX_FLG1);
   wire         wSlcFlg  = wrStb & hit(paddr, IDX_SLC_FLG);
   wire         wE1Flg   = wrStb & hit(paddr, IDX_E1_FLG);
   wire         wE1Ctrl  = wrStb & hit(paddr, IDX_E1_CTRL);

   // Modes
   wire         unframed = mode0_ff[MODE0_UNFRAMED];
   wire         framed   = ~unframed;
   wire         e1Mode   = e1Ctrl_ff[E1C_MODE] & framed;
   wire         t1Mode   = ~e1Ctrl_ff[E1C_MODE] & framed;
   wire         isEsf    = fmt == FMT_ESF;
   wire         isSlc    = fmt == FMT_SLC;
   wire fei_per_t perSel = fei_per_t'(e1Ctrl_ff[E1C_PSEL_LO +: 2]);

   // Event sources
   wire         oofNow   = framed & evt.oofCond;
   wire         oofEdge  = oofNow ^ oofState_ff;
   wire         slcUpd   = t1Mode & isSlc & slc.valid;
   wire [3:0]   slcChg   = {4{slcUpd}} & {slc.sw != sw_ff, slc.alarm != alarm_ff,
                                          slc.maint != maint_ff, slc.conc != conc_ff};
   wire [7:0]   set0     = {7'h00, oofEdge};
   wire [7:0]   set1;
   assign set1[B_MFSTART] = t1Mode & evt.mfStart;
   assign set1[B_ALIGN]   = t1Mode & evt.alignChg;
   assign set1[B_FBIT]    = t1Mode & evt.fbitErr;
   assign set1[B_CRC6]    = t1Mode & isEsf & evt.crc6Err;
   assign set1[B_SEVERE]  = t1Mode & ~isSlc & evt.severeErr;
   assign set1[7:5]       = 3'h0;

   // Periodic E1 event
   wire         perEvt   = e1Mode & (perSel == PER_FRAME ? e1.frameStb :
                                     perSel == PER_SMF   ? e1.smfStb :
                                     perSel == PER_MF    ? e1.mfStb : e1.sigMf0Stb);
   wire         perSet   = perEvt & e1Ctrl_ff[E1C_PIRQ_EN];

   // Flags: set wins over a same-cycle clear
   wire [7:0]   nxt_flg0   = (flg0_ff & ~({8{wFlg0}} & wd)) | set0;
   wire [7:0]   nxt_flg1   = (flg1_ff & ~({8{wFlg1}} & wd)) | set1;
   wire [7:0]   nxt_slcFlg = (slcFlg_ff & ~({8{wSlcFlg}} & wd)) | {4'h0, slcChg};
   wire [7:0]   nxt_e1Flg  = (e1Flg_ff & ~({8{wE1Flg}} & wd)) | {7'h00, perSet};
   wire         nxt_intN   = ~|{flg0_ff & en0_ff, flg1_ff & en1_ff,
                                slcFlg_ff & slcEn_ff, e1Flg_ff & {7'h00, e1Ctrl_ff[E1C_PIRQ_EN]}};

   // Reframe: host flag edge, or E1 software reset
   wire         refrRise = mode0_ff[MODE0_REFRAME] & ~refrLast_ff;
   wire         swRst    = wE1Ctrl & wd[E1C_SWRST] & e1Ctrl_ff[E1C_MODE];

   // Remote alarm sources
   assign rawRem[0] = e1.ts0[5];
   assign rawRem[1] = e1.ts16[2];
   wire [1:0]   remStb   = {2{e1Mode}} & {e1.sigMf0Stb, e1.nfasStb};
   wire [2:0]   debN     = e1Ctrl_ff[E1C_DEB4] ? DEB_LONG : DEB_SHORT;

   // Sa codeword bit, chosen from Sa4..Sa8
   wire [2:0]   saIdx    = (saSel_ff[2:0] > 3'h4) ? 3'h0 : 3'h4 - saSel_ff[2:0];
   wire         saBit    = e1.ts0[saIdx];

   // Read mux
   wire [7:0]   e1Stat   = {1'b0, red_ff, ais_ff, remVal_ff, ~e1.casMfSync,
                            ~e1.crcMfSync, ~e1.basicSync};
   wire         known    = hit(paddr, IDX_MODE0) | hit(paddr, IDX_MODE1) | hit(paddr, IDX_SYNC)
                         | hit(paddr, IDX_EN0) | hit(paddr, IDX_EN1) | hit(paddr, IDX_FLG0)
                         | hit(paddr, IDX_FLG1) | hit(paddr, IDX_SLC_LO) | hit(paddr, IDX_SLC_MID)
                         | hit(paddr, IDX_SLC_HI) | hit(paddr, IDX_SLC_EN) | hit(paddr, IDX_SLC_FLG)
                         | hit(paddr, IDX_E1_CTRL) | hit(paddr, IDX_E1_STAT) | hit(paddr, IDX_E1_FLG)
                         | hit(paddr, IDX_E1_SI) | hit(paddr, IDX_E1_SA) | hit(paddr, IDX_E1_XBITS)
                         | hit(paddr, IDX_E1_CODE) | hit(paddr, IDX_E1_SASEL);
   wire [7:0]   rdByte   =
        hit(paddr, IDX_MODE0)   ? mode0_ff :
        hit(paddr, IDX_MODE1)   ? mode1_ff :
        hit(paddr, IDX_SYNC)    ? {7'h00, oofState_ff} :
        hit(paddr, IDX_EN0)     ? en0_ff :
        hit(paddr, IDX_EN1)     ? en1_ff :
        hit(paddr, IDX_FLG0)    ? flg0_ff :
        hit(paddr, IDX_FLG1)    ? flg1_ff :
        hit(paddr, IDX_SLC_LO)  ? conc_ff[7:0] :
        hit(paddr, IDX_SLC_MID) ? {1'b0, maint_ff, 1'b0, conc_ff[10:8]} :
        hit(paddr, IDX_SLC_HI)  ? {sw_ff, 2'h0, alarm_ff} :
        hit(paddr, IDX_SLC_EN)  ? slcEn_ff :
        hit(paddr, IDX_SLC_FLG) ? slcFlg_ff :
        hit(paddr, IDX_E1_CTRL) ? e1Ctrl_ff :
        hit(paddr, IDX_E1_STAT) ? e1Stat :
        hit(paddr, IDX_E1_FLG)  ? e1Flg_ff :
        hit(paddr, IDX_E1_SI)   ? {6'h00, si_ff} :
        hit(paddr, IDX_E1_SA)   ? {3'h0, sa_ff} :
        hit(paddr, IDX_E1_XBITS)? {5'h00, xbits_ff} :
        hit(paddr, IDX_E1_CODE) ? {4'h0, code_ff} :
        hit(paddr, IDX_E1_SASEL)? saSel_ff : 8'h00;

   // APB: one wait state, answer registered
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end
      else
      begin
         pready_ff  <= psel & penable & ~pready_ff;
         pslverr_ff <= psel & penable & ~pready_ff & ~known;
         prdata_ff  <= (psel & ~pwrite) ? {24'h00_0000, rdByte} : 32'h0000_0000;
      end
   end

   // Host-written configuration
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         mode0_ff  <= RST_REG;
         mode1_ff  <= RST_REG;
         en0_ff    <= RST_REG;
         en1_ff    <= RST_REG;
         slcEn_ff  <= RST_REG;
         e1Ctrl_ff <= RST_REG;
         saSel_ff  <= RST_REG;
      end
      else
      begin
         if (wMode0)
            mode0_ff <= wd;
         if (wrStb & hit(paddr, IDX_MODE1))
            mode1_ff <= wd;
         if (wrStb & hit(paddr, IDX_EN0))
            en0_ff <= {7'h00, wd[0]};
         if (wrStb & hit(paddr, IDX_EN1))
            en1_ff <= {3'h0, wd[4:0]};
         if (wrStb & hit(paddr, IDX_SLC_EN))
            slcEn_ff <= {4'h0, wd[3:0]};
         if (wE1Ctrl)
            e1Ctrl_ff <= wd & ~(8'h01 << E1C_SWRST);
         if (wrStb & hit(paddr, IDX_E1_SASEL))
            saSel_ff <= {5'h00, wd[2:0]};
      end
   end

   // Flags, interrupt pin and reframe
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         flg0_ff     <= RST_REG;
         flg1_ff     <= RST_REG;
         slcFlg_ff   <= RST_REG;
         e1Flg_ff    <= RST_REG;
         oofState_ff <= 1'b0;
         refrLast_ff <= 1'b0;
         intN_ff     <= 1'b1;
         reframe_ff  <= 1'b0;
      end
      else
      begin
         flg0_ff     <= nxt_flg0;
         flg1_ff     <= nxt_flg1;
         slcFlg_ff   <= nxt_slcFlg;
         e1Flg_ff    <= nxt_e1Flg;
         oofState_ff <= oofNow;
         refrLast_ff <= mode0_ff[MODE0_REFRAME];
         intN_ff     <= nxt_intN;
         reframe_ff  <= framed & (refrRise | swRst);
      end
   end

   // SLC-96 overhead; held while no valid word arrives
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         conc_ff  <= 11'h000;
         maint_ff <= 3'h0;
         alarm_ff <= 2'h0;
         sw_ff    <= 4'h0;
      end
      else if (slcUpd)
      begin
         conc_ff  <= slc.conc;
         maint_ff <= slc.maint;
         alarm_ff <= slc.alarm;
         sw_ff    <= slc.sw;
      end
   end

   // E1 captures and TS16 pin
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ts16_ff      <= 1'b0;
         si_ff        <= 2'h0;
         sa_ff        <= 5'h00;
         xbits_ff     <= 3'h0;
         codeShift_ff <= 4'h0;
         codeCnt_ff   <= 3'h0;
         code_ff      <= 4'h0;
      end
      else
      begin
         if (e1Mode & e1.ts16BitVld)
            ts16_ff <= e1.ts16Bit;
         if (e1Mode & e1.fasStb)
            si_ff[0] <= e1.ts0[7];
         if (e1Mode & e1.nfasStb)
         begin
            si_ff[1]     <= e1.ts0[7];
            sa_ff        <= e1.ts0[4:0];
            codeShift_ff <= {codeShift_ff[2:0], saBit};
            codeCnt_ff   <= codeCnt_ff + 3'h1;
         end
         if (e1Mode & e1.sigMf0Stb)
            xbits_ff <= {e1.ts16[3], e1.ts16[1], e1.ts16[0]};
         // Codeword only latched once a full four NFAS bits were seen
         if (e1Mode & e1.smfStb)
         begin
            codeCnt_ff <= 3'h0;
            if (codeCnt_ff >= 3'h4)
               code_ff <= codeShift_ff;
         end
      end
   end

   // Remote alarm debounce, one lane per source
   for (genvar g = 0; g < 2; g++)
   begin : gRem
      always_ff @(posedge sys_clk)
      begin
         if (rst)
         begin
            remLast_ff[g] <= 1'b0;
            remCnt_ff[g]  <= 3'h0;
            remVal_ff[g]  <= 1'b0;
         end
         else if (~e1Mode)
         begin
            remCnt_ff[g] <= 3'h0;
            remVal_ff[g] <= 1'b0;
         end
         else if (remStb[g])
         begin
            remLast_ff[g] <= rawRem[g];
            if (remCnt_ff[g] != 3'h0 && rawRem[g] != remLast_ff[g])
               remCnt_ff[g] <= 3'h1;
            else if (remCnt_ff[g] < DEB_LONG)
               remCnt_ff[g] <= remCnt_ff[g] + 3'h1;
            if ((remCnt_ff[g] != 3'h0 && rawRem[g] == remLast_ff[g] && remCnt_ff[g] + 3'h1 >= debN)
                || (debN == DEB_SHORT))
               remVal_ff[g] <= rawRem[g];
         end
      end
   end

   // AIS: too few zeros in a fixed bit window; red alarm on long loss
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         aisBits_ff  <= 9'h000;
         aisZeros_ff <= 9'h000;
         ais_ff      <= 1'b0;
         redCnt_ff   <= 20'h00000;
         red_ff      <= 1'b0;
      end
      else
      begin
         if (framed & e1.rxBitVld)
         begin
            aisBits_ff <= aisBits_ff + 9'h001;
            if (aisBits_ff == AIS_WINDOW_LAST)
            begin
               ais_ff      <= (aisZeros_ff + {8'h00, ~e1.rxBit}) < AIS_ZERO_MAX;
               aisZeros_ff <= 9'h000;
            end
            else if (~e1.rxBit)
               aisZeros_ff <= aisZeros_ff + 9'h001;
         end
         // Counter saturates so the alarm stays up while loss persists
         if (~framed | e1.basicSync)
         begin
            redCnt_ff <= 20'h00000;
            red_ff    <= 1'b0;
         end
         else if (redCnt_ff >= 20'(RED_COUNT - 1))
            red_ff <= 1'b1;
         else
            redCnt_ff <= redCnt_ff + 20'h00001;
      end
   end

   // Output drive
   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign intN       = intN_ff;
   assign reframeReq = reframe_ff;
   assign ts16Out    = ts16_ff;
   assign bypass     = mode0_ff[MODE0_UNFRAMED];

endmodule

// ==== fei_framer_irq_asserts.sv ====
// Assertion checker for the framer event and interrupt block
module fei_framer_irq_asserts
   import fei_pkg::*;
#(
   parameter int RED_COUNT = RED_CYCLES
)
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Framer side
   input wire fei_fmt_t    fmt,
   input wire fei_evt_t    evt,
   input wire fei_slc_t    slc,
   input wire fei_e1_t     e1,
   // Outputs
   input wire logic        intN,
   input wire logic        reframeReq,
   input wire logic        ts16Out,
   input wire logic        bypass
);
   wire logic acc    = psel && penable && pready;
   wire logic wrAny  = acc && pwrite;
   wire logic wrMode = wrAny && paddr == {IDX_MODE0, 2'b00};

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_wait;
      !pready ##1 pready;
   endsequence

   property p_rst;
      disable iff (1'b0) rst |=> intN && !pready && !pslverr && !reframeReq && !bypass && prdata == 32'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not at reset level");

   property p_wait;
      psel && !penable |=> s_wait;
   endproperty
   a_wait: assert property (p_wait) else $error("ready not after one wait state");

   property p_rdy1;
      pready |=> !pready;
   endproperty
   a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");

   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");

   property p_unmapped;
      acc && paddr[11:2] > IDX_E1_SASEL |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");

   property p_bypass;
      wrMode |-> ##2 bypass == $past(pwdata[7], 2);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not following mode bit");

   property p_int_rise;
      $rose(intN) |-> $past(wrAny) || $past(wrAny, 2);
   endproperty
   a_int_rise: assert property (p_int_rise) else $error("interrupt released without host write");

   property p_reframe;
      reframeReq |=> !reframeReq;
   endproperty
   a_reframe: assert property (p_reframe) else $error("reframe request held high");

   property p_reframe_cause;
      reframeReq |-> $past(wrAny) || $past(wrAny, 2);
   endproperty
   a_reframe_cause: assert property (p_reframe_cause) else $error("reframe without host write");

   property p_ts16;
      $changed(ts16Out) |-> $past(e1.ts16BitVld);
   endproperty
   a_ts16: assert property (p_ts16) else $error("slot output changed without bit");
endmodule

// ==== fei_pkg.sv ====
// Constants and types for the framer event and interrupt block
package fei_pkg;

   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_MODE0    = 10'h04d;
   localparam logic [9:0] IDX_MODE1    = 10'h04e;
   localparam logic [9:0] IDX_SYNC     = 10'h04f;
   localparam logic [9:0] IDX_EN0      = 10'h050;
   localparam logic [9:0] IDX_EN1      = 10'h051;
   localparam logic [9:0] IDX_FLG0     = 10'h052;
   localparam logic [9:0] IDX_FLG1     = 10'h053;
   localparam logic [9:0] IDX_SLC_LO   = 10'h056;
   localparam logic [9:0] IDX_SLC_MID  = 10'h057;
   localparam logic [9:0] IDX_SLC_HI   = 10'h058;
   localparam logic [9:0] IDX_SLC_EN   = 10'h05c;
   localparam logic [9:0] IDX_SLC_FLG  = 10'h05d;
   localparam logic [9:0] IDX_E1_CTRL  = 10'h060;
   localparam logic [9:0] IDX_E1_STAT  = 10'h061;
   localparam logic [9:0] IDX_E1_FLG   = 10'h062;
   localparam logic [9:0] IDX_E1_SI    = 10'h063;
   localparam logic [9:0] IDX_E1_SA    = 10'h064;
   localparam logic [9:0] IDX_E1_XBITS = 10'h065;
   localparam logic [9:0] IDX_E1_CODE  = 10'h066;
   localparam logic [9:0] IDX_E1_SASEL = 10'h067;

   localparam logic [7:0] RST_REG = 8'h00;

   // Mode 0 fields
   localparam int MODE0_UNFRAMED = 7;
   localparam int MODE0_REFRAME  = 5;
   // Enable/flag bit positions, register 1
   localparam int B_MFSTART = 4;
   localparam int B_SEVERE  = 3;
   localparam int B_CRC6    = 2;
   localparam int B_FBIT    = 1;
   localparam int B_ALIGN   = 0;
   // E1 control fields
   localparam int E1C_MODE    = 0;
   localparam int E1C_SWRST   = 1;
   localparam int E1C_DEB4    = 2;
   localparam int E1C_PSEL_LO = 3;
   localparam int E1C_PIRQ_EN = 5;

   // Debounce counts
   localparam logic [2:0] DEB_SHORT = 3'h1;
   localparam logic [2:0] DEB_LONG  = 3'h4;
   // All-ones detection window and zero tolerance
   localparam logic [8:0] AIS_WINDOW_LAST = 9'h1ff;
   localparam logic [8:0] AIS_ZERO_MAX    = 9'h003;
   // Red alarm persistence
   localparam int RED_TIME_MS = 100;
   localparam int CLK_HZ      = 10_000_000;
   localparam int RED_CYCLES  = RED_TIME_MS * (CLK_HZ / 1000);

   typedef enum logic [1:0] {FMT_SF, FMT_ESF, FMT_DM, FMT_SLC} fei_fmt_t;
   typedef enum logic [1:0] {PER_FRAME, PER_SMF, PER_MF, PER_SIGMF} fei_per_t;

   // Framing events from the receive framer core
   typedef struct packed {
      logic oofCond;
      logic mfStart;
      logic alignChg;
      logic fbitErr;
      logic crc6Err;
      logic severeErr;
   } fei_evt_t;

   // SLC-96 overhead word
   typedef struct packed {
      logic       valid;
      logic [10:0] conc;
      logic [2:0]  maint;
      logic [1:0]  alarm;
      logic [3:0]  sw;
   } fei_slc_t;

   // E1 timeslot strobes and line bits
   typedef struct packed {
      logic       frameStb;
      logic       fasStb;
      logic       nfasStb;
      logic [7:0] ts0;
      logic       sigMf0Stb;
      logic [7:0] ts16;
      logic       smfStb;
      logic       mfStb;
      logic       ts16BitVld;
      logic       ts16Bit;
      logic       rxBitVld;
      logic       rxBit;
      logic       basicSync;
      logic       crcMfSync;
      logic       casMfSync;
   } fei_e1_t;

endpackage

// ==== fei_rx_model.sv ====
// Behavioural receive line side feeding framing events into the block
module fei_rx_model
   import fei_pkg::*;
(
   // Clock
   input  wire logic sys_clk,
   // Framer side
   output fei_fmt_t  fmt,
   output fei_evt_t  evt,
   output fei_slc_t  slc,
   output fei_e1_t   e1
);
   initial
   begin
      fmt = FMT_SF;
      evt = '0;
      slc = '0;
      e1  = '0;
   end

   task automatic pulse(input int b);
      evt[b] <= 1'b1;
      @(posedge sys_clk);
      evt[b] <= 1'b0;
   endtask

   // Fields inverted after the strobe so stale data never looks valid
   task automatic slcWord(input logic [19:0] w);
      slc <= {1'b1, w};
      @(posedge sys_clk);
      slc <= {1'b0, ~w};
   endtask

   task automatic ts16Bit(input logic b);
      e1.ts16BitVld <= 1'b1;
      e1.ts16Bit    <= b;
      @(posedge sys_clk);
      e1.ts16BitVld <= 1'b0;
      e1.ts16Bit    <= ~b;
   endtask

   // One NFAS basic frame; slot byte inverted afterwards like the others
   task automatic nfasFrame(input logic [7:0] t0);
      e1.frameStb <= 1'b1;
      e1.nfasStb  <= 1'b1;
      e1.ts0      <= t0;
      @(posedge sys_clk);
      e1.frameStb <= 1'b0;
      e1.nfasStb  <= 1'b0;
      e1.ts0      <= ~t0;
   endtask
endmodule

// ==== framer_event_interrupts_tb_top.sv ====
// Testbench for the framer event and interrupt block
module framer_event_interrupts_tb_top
   import fei_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RC = 50;
   logic [9:0]  allRegs[$] = '{IDX_MODE0, IDX_MODE1, IDX_SYNC, IDX_EN0, IDX_EN1, IDX_FLG0, IDX_FLG1,
                               IDX_SLC_LO, IDX_SLC_MID, IDX_SLC_HI, IDX_SLC_EN, IDX_SLC_FLG};
   logic [9:0]  rwRegs[$] = '{IDX_MODE1, IDX_EN0, IDX_EN1, IDX_SLC_EN};
   // Implemented bits of each storage register; the rest read as zero
   logic [7:0]  rwMask[$] = '{8'hff, 8'h01, 8'h1f, 8'h0f};
   logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   fei_fmt_t    fmt;
   fei_evt_t    evt;
   fei_slc_t    slc;
   fei_e1_t     e1;
   logic        intN, reframeReq, ts16Out, bypass;
   int          mismatches, comparisons, cycles, pulses;
   logic [19:0] w, prevW;
   logic [7:0]  d, expF;

   fei_rx_model rx (.sys_clk(sys_clk), .fmt(fmt), .evt(evt), .slc(slc), .e1(e1));
   fei_framer_irq #(.RED_COUNT(RC)) DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fmt(fmt), .evt(evt), .slc(slc), .e1(e1), .intN(intN),
      .reframeReq(reframeReq), .ts16Out(ts16Out), .bypass(bypass));

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic summarize;
      if (mismatches == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (reframeReq === 1'b1)
         pulses++;
      if (cycles > 20000)
      begin
         mismatches++;
         summarize();
      end
   end

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      comparisons++;
      if (got !== ex)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Holds the request until ready is sampled high
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] dat);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h0, dat};
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Idle cycle so a following setup never drives psel twice in one step
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] dat);
      apb(1'b1, idx, dat);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [7:0] ex);
      apb(1'b0, idx, 8'h00);
      chk($sformatf("reg %h", idx), {24'h0, ex}, q);
   endtask

   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      prevW = '0;
      void'($urandom(32'haf0cf035));
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      foreach (allRegs[i])
         rd(allRegs[i], RST_REG);
      apb(1'b0, 10'h3ff, 8'h00);
      chk("unmapped error", 32'h1, {31'h0, e});
      foreach (rwRegs[i])
      begin
         d = 8'($urandom);
         wr(rwRegs[i], d);
         rd(rwRegs[i], d & rwMask[i]);
         wr(rwRegs[i], 8'h00);
      end
      wr(IDX_SYNC, 8'hff);
      rd(IDX_SYNC, 8'h00);
      wr(IDX_EN1, 8'h1f);
      for (int f = 0; f < 4; f++)
      begin
         rx.fmt <= fei_fmt_t'(f);
         for (int b = 0; b < 5; b++)
            rx.pulse(b);
         expF = 8'h1f & ~(f == 1 ? 8'h00 : 8'h04) & ~(f == 3 ? 8'h08 : 8'h00);
         rd(IDX_FLG1, expF);
         chk("intN", 32'h0, {31'h0, intN});
         wr(IDX_FLG1, 8'h00);
         rd(IDX_FLG1, expF);
         wr(IDX_FLG1, 8'hff);
         rd(IDX_FLG1, 8'h00);
         chk("intN", 32'h1, {31'h0, intN});
      end
      wr(IDX_EN1, 8'h00);
      rx.pulse(4);
      rd(IDX_FLG1, 8'h10);
      chk("intN", 32'h1, {31'h0, intN});
      wr(IDX_EN1, 8'h10);
      rd(IDX_FLG1, 8'h10);
      chk("intN", 32'h0, {31'h0, intN});
      wr(IDX_FLG1, 8'h10);
      wr(IDX_EN0, 8'h01);
      rx.evt.oofCond <= 1'b1;
      rd(IDX_SYNC, 8'h01);
      rd(IDX_FLG0, 8'h01);
      wr(IDX_FLG0, 8'h01);
      rx.evt.oofCond <= 1'b0;
      rd(IDX_FLG0, 8'h01);
      rd(IDX_SYNC, 8'h00);
      wr(IDX_FLG0, 8'h01);
      wr(IDX_SLC_EN, 8'h0f);
      for (int k = 0; k < 3; k++)
      begin
         w = (k == 2) ? prevW : 20'($urandom);
         expF = {4'h0, w[3:0] != prevW[3:0], w[5:4] != prevW[5:4], w[8:6] != prevW[8:6], w[19:9] != prevW[19:9]};
         rx.slcWord(w);
         rd(IDX_SLC_FLG, expF);
         rd(IDX_SLC_LO, w[16:9]);
         rd(IDX_SLC_MID, {1'b0, w[8:6], 1'b0, w[19:17]});
         rd(IDX_SLC_HI, {w[3:0], 2'b00, w[5:4]});
         wr(IDX_SLC_FLG, 8'h0f);
         prevW = w;
      end
      wr(IDX_MODE0, 8'h20);
      wr(IDX_MODE0, 8'h20);
      wr(IDX_MODE0, 8'h00);
      wr(IDX_MODE0, 8'h20);
      repeat (3) @(posedge sys_clk);
      chk("reframe pulses", 32'd2, pulses);
      wr(IDX_MODE0, 8'h80);
      repeat (2) @(posedge sys_clk);
      chk("bypass", 32'h1, {31'h0, bypass});
      rx.pulse(4);
      rd(IDX_FLG1, 8'h00);
      wr(IDX_MODE0, 8'h00);
      wr(IDX_E1_CTRL, 8'h01);
      for (int b = 1; b >= 0; b--)
      begin
         rx.ts16Bit(b[0]);
         @(posedge sys_clk);
         chk("ts16Out", {31'h0, b[0]}, {31'h0, ts16Out});
      end
      wr(IDX_E1_CTRL, 8'h03);
      repeat (3) @(posedge sys_clk);
      chk("reframe pulses", 32'd3, pulses);
      wr(IDX_E1_CTRL, 8'h21);
      rx.nfasFrame(8'h20);
      rd(IDX_E1_FLG, 8'h01);
      chk("intN", 32'h0, {31'h0, intN});
      wr(IDX_E1_FLG, 8'h01);
      repeat (RC) @(posedge sys_clk);
      chk("intN", 32'h1, {31'h0, intN});
      // Alarm taken on first occurrence; red alarm up after the loss time
      rd(IDX_E1_STAT, 8'h4f);
      wr(IDX_E1_CTRL, 8'h05);
      for (int k = 0; k < 4; k++)
      begin
         rx.nfasFrame(8'h8a);
         rd(IDX_E1_STAT, (k == 3) ? 8'h47 : 8'h4f);
      end
      rd(IDX_E1_SA, 8'h0a);
      rd(IDX_E1_SI, 8'h02);
      rx.e1.basicSync <= 1'b1;
      rd(IDX_E1_STAT, 8'h06);
      summarize();
   end
endmodule

bind fei_framer_irq fei_framer_irq_asserts #(.RED_COUNT(RED_COUNT)) uChk (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fmt(fmt), .evt(evt),
   .slc(slc), .e1(e1), .intN(intN), .reframeReq(reframeReq), .ts16Out(ts16Out), .bypass(bypass));
